// [verilog/oif_regs.svh]
// constants for the octal input filter and fault monitor
`ifndef OIF_REGS_SVH
`define OIF_REGS_SVH

// ------------------------------------------------------------
// clocking and filter timing
// ------------------------------------------------------------
`define OIF_CLOCK_HZ 25000000
`define OIF_FILT_RATE_HZ 200000
`define OIF_TICK_DIV (`OIF_CLOCK_HZ / `OIF_FILT_RATE_HZ)
`define OIF_DIV_W 7
`define OIF_CNT_W 12
`define OIF_DLY0_US 50
`define OIF_DLY1_US 100
`define OIF_DLY2_US 400
`define OIF_DLY3_US 800
`define OIF_DLY4_US 1600
`define OIF_DLY5_US 3200
`define OIF_DLY6_US 12800
`define OIF_DLY7_US 20000
`define OIF_WB_DLY_SEL 3'h7

// ------------------------------------------------------------
// fault pin pulse stretch
// ------------------------------------------------------------
`define OIF_STRETCH_NS 1000
`define OIF_STRETCH_CYC \
	((`OIF_STRETCH_NS * (`OIF_CLOCK_HZ / 1000000) + 999) / 1000)
`define OIF_STR_W 5

// ------------------------------------------------------------
// primary fault flag positions and reset values
// ------------------------------------------------------------
`define OIF_PF_SUP_LOW 0
`define OIF_PF_SUP_MISS 1
`define OIF_PF_OT1 2
`define OIF_PF_OT2 3
`define OIF_PF_CRC 4
`define OIF_PF_POR 5
`define OIF_PF_WBG 6
`define OIF_PF_LATCHED 8'h0f
`define OIF_PRI_FLAGS_RST 8'h20
`define OIF_PRI_EN_RST 8'h30
`define OIF_SEC_EN_RST 8'h00
`define OIF_STICKY_RST 1'b0

`endif

// [verilog/oif_pkg.sv]
// types shared by the octal input filter and fault monitor
`include "oif_regs.svh"

package oif_pkg;

	typedef struct packed {
		logic fault_in;
		logic ot2;
		logic ot1;
		logic sup_miss;
		logic sup_low;
		logic latch_n;
		logic cs_n;
		logic [7:0] trip;
		logic [7:0] field;
	} oif_pins_t;

	typedef struct packed {
		logic [`OIF_CNT_W-1:0] cnt;
		logic level;
	} oif_filt_t;

	typedef struct packed {
		oif_pins_t s1;
		oif_pins_t s2;
		logic [`OIF_DIV_W-1:0] div;
		logic tick;
		logic [7:0] chan_cap;
		logic [7:0] wb_in;
		logic [7:0] wb_flags;
		logic [7:0] pri_flags;
		logic [7:0] sec_flags;
		logic [7:0] pri_en;
		logic [7:0] sec_en;
		logic sticky;
		logic [`OIF_STR_W-1:0] stretch;
		logic fault_oe;
	} oif_state_t;

endpackage : oif_pkg

// [verilog/oif_chan_filter.sv]
// one saturating up-down debounce counter
`timescale 1ns/100ps
`default_nettype none
`include "oif_regs.svh"

module oif_chan_filter
	import oif_pkg::*;
(
	input wire logic i_clock, // 25 MHz
	input wire logic i_rst, // async, active high
	input wire logic i_enable, // clock enable
	input wire logic i_tick, // 200 kHz count pulse
	input wire logic i_raw, // synchronised comparator
	input wire logic [2:0] i_delay_sel, // delay code
	output logic o_level // debounced level
);

	oif_filt_t st_ff;
	oif_filt_t nxt_st;
	logic [`OIF_CNT_W-1:0] lim;

	// ------------------------------------------------------------
	// limit lookup
	// ------------------------------------------------------------
	function automatic logic [`OIF_CNT_W-1:0] limit_of(
		input logic [2:0] sel);
		int us;
		unique case (sel)
			3'h0: us = `OIF_DLY0_US;
			3'h1: us = `OIF_DLY1_US;
			3'h2: us = `OIF_DLY2_US;
			3'h3: us = `OIF_DLY3_US;
			3'h4: us = `OIF_DLY4_US;
			3'h5: us = `OIF_DLY5_US;
			3'h6: us = `OIF_DLY6_US;
			3'h7: us = `OIF_DLY7_US;
		endcase
		// split the rate so the product stays in 32 bits
		limit_of = `OIF_CNT_W'(us * (`OIF_FILT_RATE_HZ / 1000) / 1000);
	endfunction : limit_of

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_comb begin
		lim = limit_of(i_delay_sel);
		nxt_st = st_ff;
		if (i_tick) begin
			if (i_raw) begin
				if (st_ff.cnt < lim) begin
					nxt_st.cnt = st_ff.cnt + 1'b1;
				end else begin
					nxt_st.cnt = lim;
				end
			end else if (st_ff.cnt != '0) begin
				nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			if (nxt_st.cnt == lim) begin
				nxt_st.level = 1'b1;
			end else if (nxt_st.cnt == '0) begin
				nxt_st.level = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else if (i_enable) begin
			st_ff <= nxt_st;
		end
	end

	assign o_level = st_ff.level;

endmodule : oif_chan_filter

`default_nettype wire

// [verilog/oif_monitor.sv]
// octal input filter, wire-break flags and fault pin logic
`timescale 1ns/100ps
`default_nettype none
`include "oif_regs.svh"

module oif_monitor
	import oif_pkg::*;
#(
	parameter int TICK_DIV = `OIF_TICK_DIV // clocks per filter count
)
(
	input wire logic i_clock, // 25 MHz
	input wire logic i_rst, // async, active high
	input wire logic i_enable, // clock enable
	// field side pins
	input wire logic [7:0] i_field_channels, // input comparators
	input wire logic [7:0] i_wire_trip, // 1 = current missing
	input wire logic i_supply_low, // field supply low
	input wire logic i_supply_missing, // field supply missing
	input wire logic i_overtemp_first, // temperature alarm 1
	input wire logic i_overtemp_second, // temperature alarm 2
	// host strobes, pins
	input wire logic i_cs_n, // chip-select, active low
	input wire logic i_latch_n, // latch strobe, active low
	// configuration
	input wire logic [7:0] i_filter_bypass, // per channel bypass
	input wire logic [23:0] i_channel_filter_config, // 3 bits/ch
	input wire logic [7:0] i_wire_break_enable, // per channel
	input wire logic i_cfg_write, // load enables and sticky
	input wire logic [7:0] i_primary_fault_enables, // data
	input wire logic [7:0] i_secondary_fault_enables, // data
	input wire logic i_fault_pin_sticky, // data
	// serial side events, same clock
	input wire logic i_frame_done, // frame ended, pulse
	input wire logic i_frame_crc_bad, // with i_frame_done
	input wire logic [7:0] i_secondary_events, // fault levels
	input wire logic i_read_wire_break, // read pulse
	input wire logic i_read_primary, // read pulse
	input wire logic i_read_secondary, // read pulse
	// captured data and flags
	output logic [7:0] o_field_channels, // frozen inputs
	output logic [7:0] o_wire_break_flags, // sticky flags
	output logic [7:0] o_primary_fault_flags, // primary flags
	output logic [7:0] o_secondary_fault_flags, // sticky flags
	output logic [7:0] o_primary_fault_enables, // readback
	output logic [7:0] o_secondary_fault_enables, // readback
	output logic o_fault_pin_sticky, // readback
	// open-drain fault pin
	input wire logic i_fault_in, // wire level
	output logic o_fault_out, // always low
	output logic o_fault_oe, // high while pulling low
	output logic o_fault_line // synchronised wire level
);

	localparam oif_state_t ST_RST = '{
		s1: '0,
		s2: '0,
		div: '0,
		tick: 1'b0,
		chan_cap: '0,
		wb_in: '0,
		wb_flags: '0,
		pri_flags: `OIF_PRI_FLAGS_RST,
		sec_flags: '0,
		pri_en: `OIF_PRI_EN_RST,
		sec_en: `OIF_SEC_EN_RST,
		sticky: `OIF_STICKY_RST,
		stretch: '0,
		fault_oe: 1'b0
	};

	localparam logic [`OIF_DIV_W-1:0] DIV_LAST =
		`OIF_DIV_W'(TICK_DIV - 1);
	localparam logic [`OIF_STR_W-1:0] STR_LOAD =
		`OIF_STR_W'(`OIF_STRETCH_CYC - 1);

	oif_state_t st_ff;
	oif_state_t nxt_st;
	oif_pins_t pins;
	logic [7:0] filt_lvl;
	logic [7:0] wb_lvl;
	logic [7:0] chan_sel;
	logic [7:0] live_pri;
	logic [7:0] act_pri;
	logic [7:0] act_sec;
	logic open;
	logic fault_any;

	// ------------------------------------------------------------
	// sticky flag update
	// ------------------------------------------------------------
	// a set in the cycle of its clear survives, so no event is lost
	function automatic logic [7:0] flag_upd(
		input logic [7:0] old,
		input logic [7:0] clr,
		input logic [7:0] set);
		flag_upd = (old & ~clr) | set;
	endfunction : flag_upd

	// ------------------------------------------------------------
	// pin gathering
	// ------------------------------------------------------------
	always_comb begin
		pins.fault_in = i_fault_in;
		pins.ot2 = i_overtemp_second;
		pins.ot1 = i_overtemp_first;
		pins.sup_miss = i_supply_missing;
		pins.sup_low = i_supply_low;
		pins.latch_n = i_latch_n;
		pins.cs_n = i_cs_n;
		pins.trip = i_wire_trip;
		pins.field = i_field_channels;
	end

	// ------------------------------------------------------------
	// channel and wire-break filters
	// ------------------------------------------------------------
	for (genvar g = 0; g < 8; g++) begin : g_chan
		oif_chan_filter u_in_filt (
			.i_clock(i_clock),
			.i_rst(i_rst),
			.i_enable(i_enable),
			.i_tick(st_ff.tick),
			.i_raw(st_ff.s2.field[g]),
			.i_delay_sel(i_channel_filter_config[3*g +: 3]),
			.o_level(filt_lvl[g])
		);
		// fixed 20ms code, no bypass path for wire-break
		oif_chan_filter u_wb_filt (
			.i_clock(i_clock),
			.i_rst(i_rst),
			.i_enable(i_enable),
			.i_tick(st_ff.tick),
			.i_raw(st_ff.s2.trip[g]),
			.i_delay_sel(`OIF_WB_DLY_SEL),
			.o_level(wb_lvl[g])
		);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// two-flop synchronisers for every pin
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;

		// 200 kHz count pulse
		if (st_ff.div == DIV_LAST) begin
			nxt_st.div = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.div = st_ff.div + 1'b1;
			nxt_st.tick = 1'b0;
		end

		// capture latch, open only while both strobes idle high
		open = st_ff.s2.cs_n & st_ff.s2.latch_n;
		chan_sel = (i_filter_bypass & st_ff.s2.field) |
			(~i_filter_bypass & filt_lvl);
		if (open) begin
			nxt_st.chan_cap = chan_sel;
			nxt_st.wb_in = wb_lvl;
		end

		// wire-break flags: a new trip beats a read in the same cycle
		nxt_st.wb_flags = flag_upd(st_ff.wb_flags, {8{i_read_wire_break}},
			st_ff.wb_in & i_wire_break_enable);

		// latched primary flags, set beats clear
		live_pri = 8'h00;
		live_pri[`OIF_PF_SUP_LOW] = st_ff.s2.sup_low;
		live_pri[`OIF_PF_SUP_MISS] = st_ff.s2.sup_miss;
		live_pri[`OIF_PF_OT1] = st_ff.s2.ot1;
		live_pri[`OIF_PF_OT2] = st_ff.s2.ot2;
		if (i_read_primary) begin
			nxt_st.pri_flags = st_ff.pri_flags & ~`OIF_PF_LATCHED;
			nxt_st.pri_flags[`OIF_PF_POR] = 1'b0;
		end
		nxt_st.pri_flags = nxt_st.pri_flags |
			(live_pri & `OIF_PF_LATCHED);

		// crc flag simply tracks the most recent frame
		if (i_frame_done) begin
			nxt_st.pri_flags[`OIF_PF_CRC] = i_frame_crc_bad;
		end

		// group flag untouched by the primary read
		nxt_st.pri_flags[`OIF_PF_WBG] = |nxt_st.wb_flags;

		// secondary flags, set beats clear
		nxt_st.sec_flags = flag_upd(st_ff.sec_flags, {8{i_read_secondary}},
			i_secondary_events);

		// configuration load
		if (i_cfg_write) begin
			nxt_st.pri_en = i_primary_fault_enables;
			nxt_st.sec_en = i_secondary_fault_enables;
			nxt_st.sticky = i_fault_pin_sticky;
		end

		// non-sticky pin tracks live conditions plus the crc and power-on flags, sticky tracks flags
		live_pri[`OIF_PF_CRC] = st_ff.pri_flags[`OIF_PF_CRC];
		live_pri[`OIF_PF_POR] = st_ff.pri_flags[`OIF_PF_POR];
		live_pri[`OIF_PF_WBG] = |(wb_lvl & i_wire_break_enable);
		act_pri = st_ff.sticky ? st_ff.pri_flags : live_pri;
		act_sec = st_ff.sticky ? st_ff.sec_flags : i_secondary_events;
		fault_any = |(act_pri & st_ff.pri_en) |
			|(act_sec & st_ff.sec_en);

		// stretch so a one-cycle fault still gives a 1us low pulse
		if (fault_any) begin
			nxt_st.stretch = STR_LOAD;
		end else if (st_ff.stretch != '0) begin
			nxt_st.stretch = st_ff.stretch - 1'b1;
		end
		nxt_st.fault_oe = fault_any | (st_ff.stretch != '0);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= ST_RST;
		end else if (i_enable) begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_field_channels = st_ff.chan_cap;
	assign o_wire_break_flags = st_ff.wb_flags;
	assign o_primary_fault_flags = st_ff.pri_flags;
	assign o_secondary_fault_flags = st_ff.sec_flags;
	assign o_primary_fault_enables = st_ff.pri_en;
	assign o_secondary_fault_enables = st_ff.sec_en;
	assign o_fault_pin_sticky = st_ff.sticky;
	assign o_fault_out = 1'b0;
	assign o_fault_oe = st_ff.fault_oe;
	assign o_fault_line = st_ff.s2.fault_in;

endmodule : oif_monitor

`default_nettype wire

// [bench/oif_monitor_assertions.sv]
// concurrent checks on the flag and fault pin outputs of oif_monitor
`timescale 1ns/100ps
`default_nettype none

module oif_monitor_assertions
	import oif_pkg::*;
(
	input wire logic i_clock, // clock
	input wire logic i_rst, // reset
	input wire logic i_frame_done, // frame end
	input wire logic i_frame_crc_bad, // bad frame
	input wire logic i_read_primary, // read pulse
	input wire logic i_read_secondary, // read pulse
	input wire logic i_cfg_write, // config load
	input wire logic [7:0] i_primary_fault_enables, // data
	input wire logic [7:0] i_secondary_events, // events
	input wire logic [7:0] i_wire_break_enable, // enables
	input wire logic [7:0] o_wire_break_flags, // flags
	input wire logic [7:0] o_primary_fault_flags, // flags
	input wire logic [7:0] o_secondary_fault_flags, // flags
	input wire logic [7:0] o_primary_fault_enables, // readback
	input wire logic o_fault_pin_sticky, // readback
	input wire logic o_fault_oe // pin drive
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------
	// low time counter
	// ----------------------------------------
	// saturates so a long fault never wraps back below the minimum
	logic [5:0] hi_cnt_ff;
	logic [5:0] nxt_hi_cnt;
	assign nxt_hi_cnt = !o_fault_oe ? 6'h00 :
		(&hi_cnt_ff ? hi_cnt_ff : hi_cnt_ff + 6'h01);
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			hi_cnt_ff <= 6'h00;
		else
			hi_cnt_ff <= nxt_hi_cnt;
	end

	sequence s_bad_frame;
		i_frame_done && i_frame_crc_bad;
	endsequence
	sequence s_good_frame;
		i_frame_done && !i_frame_crc_bad;
	endsequence
	sequence s_oe_drop;
		$fell(o_fault_oe);
	endsequence

	chk_stretch_min: assert property (s_oe_drop |-> hi_cnt_ff >= 6'h19)
		else $error("fault pin pulse too short");
	chk_crc_set: assert property (s_bad_frame |=> o_primary_fault_flags[4])
		else $error("crc flag not set");
	chk_crc_clear: assert property (s_good_frame |=> !o_primary_fault_flags[4])
		else $error("crc flag not cleared");
	chk_crc_steady: assert property ($changed(o_primary_fault_flags[4])
		|-> $past(i_frame_done))
		else $error("crc flag moved without frame");
	chk_wb_group: assert property (o_primary_fault_flags[6]
		== |o_wire_break_flags)
		else $error("group flag differs from flags");
	chk_latch_hold: assert property (|($past(o_primary_fault_flags)
		& ~o_primary_fault_flags & 8'h0f) |-> $past(i_read_primary))
		else $error("latched flag fell without read");
	chk_por_clear: assert property (i_read_primary
		|=> !o_primary_fault_flags[5])
		else $error("power-on flag survived read");
	chk_wb_gated: assert property (!(|(o_wire_break_flags
		& ~$past(o_wire_break_flags) & ~$past(i_wire_break_enable))))
		else $error("disabled channel set its flag");
	chk_sec_clear: assert property (i_read_secondary
		|=> o_secondary_fault_flags == $past(i_secondary_events))
		else $error("secondary read wrong");
	chk_cfg_load: assert property (i_cfg_write
		|=> o_primary_fault_enables == $past(i_primary_fault_enables))
		else $error("enables not loaded");
	chk_sticky_pin: assert property (o_fault_pin_sticky
		&& |(o_primary_fault_flags & o_primary_fault_enables)
		|=> o_fault_oe)
		else $error("sticky pin not driven");
endmodule : oif_monitor_assertions

bind oif_monitor oif_monitor_assertions chk_u (.i_clock, .i_rst,
	.i_frame_done, .i_frame_crc_bad, .i_read_primary, .i_read_secondary,
	.i_cfg_write, .i_primary_fault_enables, .i_secondary_events,
	.i_wire_break_enable, .o_wire_break_flags, .o_primary_fault_flags,
	.o_secondary_fault_flags, .o_primary_fault_enables,
	.o_fault_pin_sticky, .o_fault_oe);

`default_nettype wire

// [bench/oif_field_model.sv]
// field side model: comparators, supply alarm, pulled-up fault wire
`timescale 1ns/100ps
`default_nettype none

module oif_field_model (
	input wire logic i_clock, // bench clock
	input wire logic [7:0] i_want_field, // requested levels
	input wire logic [7:0] i_want_trip, // requested trips
	input wire logic i_want_low, // requested supply low
	input wire logic i_fault_oe, // device pulls line
	input wire logic i_fault_out, // device drive level
	output logic [7:0] o_field = 8'h00, // comparator levels
	output logic [7:0] o_trip = 8'h00, // wire-break levels
	output logic o_supply_low = 1'b0, // supply alarm
	output logic o_fault_wire // resolved fault line
);
	// levels follow the request one edge later, never racing the bench
	always @(posedge i_clock) begin
		o_field <= i_want_field;
		o_trip <= i_want_trip;
		o_supply_low <= i_want_low;
	end
	// pull-up owns the line whenever the device lets go
	assign o_fault_wire = i_fault_oe ? i_fault_out : 1'b1;
endmodule : oif_field_model

`default_nettype wire

// [bench/oif_monitor_test.sv]
// self-checking bench for oif_monitor
`timescale 1ns/100ps
`default_nettype none

module oif_monitor_test
	import oif_pkg::*;
;
	logic i_clock = 1'b0, i_rst = 1'b1, i_enable = 1'b1;
	logic [7:0] i_field_channels, i_wire_trip;
	logic i_supply_low, i_fault_in;
	logic i_supply_missing = 1'b0, i_overtemp_first = 1'b0;
	logic i_overtemp_second = 1'b0, i_cs_n = 1'b1, i_latch_n = 1'b1;
	logic [7:0] i_filter_bypass = 8'h00, i_wire_break_enable = 8'hff;
	logic [23:0] i_channel_filter_config = 24'h000000;
	logic i_cfg_write = 1'b0, i_fault_pin_sticky = 1'b0;
	logic [7:0] i_primary_fault_enables = 8'h30;
	logic [7:0] i_secondary_fault_enables = 8'h00;
	logic i_frame_done = 1'b0, i_frame_crc_bad = 1'b0;
	logic [7:0] i_secondary_events = 8'h00;
	logic i_read_wire_break = 1'b0, i_read_primary = 1'b0;
	logic i_read_secondary = 1'b0;
	logic [7:0] o_field_channels, o_wire_break_flags;
	logic [7:0] o_primary_fault_flags, o_secondary_fault_flags;
	logic [7:0] o_primary_fault_enables, o_secondary_fault_enables;
	logic o_fault_pin_sticky, o_fault_out, o_fault_oe, o_fault_line;
	logic [7:0] want_field = 8'h00, want_trip = 8'h00;
	logic want_low = 1'b0;
	int err_count = 0;
	int n_tests = 0;
	// fast filter count so the fixed 20ms wire-break delay fits the run
	localparam int TDIV = 5;

	always #20 i_clock = ~i_clock;

	oif_monitor #(.TICK_DIV(TDIV)) dut_u (.i_clock, .i_rst, .i_enable,
		.i_field_channels,
		.i_wire_trip, .i_supply_low, .i_supply_missing, .i_overtemp_first,
		.i_overtemp_second, .i_cs_n, .i_latch_n, .i_filter_bypass,
		.i_channel_filter_config, .i_wire_break_enable, .i_cfg_write,
		.i_primary_fault_enables, .i_secondary_fault_enables,
		.i_fault_pin_sticky, .i_frame_done, .i_frame_crc_bad,
		.i_secondary_events, .i_read_wire_break, .i_read_primary,
		.i_read_secondary, .o_field_channels, .o_wire_break_flags,
		.o_primary_fault_flags, .o_secondary_fault_flags,
		.o_primary_fault_enables, .o_secondary_fault_enables,
		.o_fault_pin_sticky, .i_fault_in, .o_fault_out, .o_fault_oe,
		.o_fault_line);

	oif_field_model fm_u (.i_clock, .i_want_field(want_field),
		.i_want_trip(want_trip), .i_want_low(want_low),
		.i_fault_oe(o_fault_oe), .i_fault_out(o_fault_out),
		.o_field(i_field_channels), .o_trip(i_wire_trip),
		.o_supply_low(i_supply_low), .o_fault_wire(i_fault_in));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask : cyc

	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk

	task automatic oe_is(input logic v);
		chk("fault_oe", {7'h00, v}, {7'h00, o_fault_oe});
	endtask : oe_is

	task automatic rd(input logic [2:0] m);
		{i_read_wire_break, i_read_primary, i_read_secondary} = m;
		cyc(1);
		{i_read_wire_break, i_read_primary, i_read_secondary} = 3'h0;
	endtask : rd

	task automatic cfg(input logic [7:0] pe, se, input logic st);
		{i_primary_fault_enables, i_secondary_fault_enables} = {pe, se};
		i_fault_pin_sticky = st;
		i_cfg_write = 1'b1;
		cyc(1);
		i_cfg_write = 1'b0;
		cyc(1);
		chk("pri_en", pe, o_primary_fault_enables);
		chk("sec_en", se, o_secondary_fault_enables);
		chk("sticky", {7'h00, st}, {7'h00, o_fault_pin_sticky});
	endtask : cfg

	task automatic frame(input logic bad);
		{i_frame_done, i_frame_crc_bad} = {1'b1, bad};
		cyc(1);
		{i_frame_done, i_frame_crc_bad} = 2'h0;
		cyc(1);
	endtask : frame

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("pri", 8'h20, o_primary_fault_flags);
		chk("pri_en", 8'h30, o_primary_fault_enables);
		chk("sticky", 8'h00, {7'h00, o_fault_pin_sticky});
		cyc(4);
		oe_is(1'b1);
		chk("line", 8'h00, {7'h00, o_fault_line});
		chk("fault_out", 8'h00, {7'h00, o_fault_out});
		rd(3'h2);
		cyc(40);
		chk("pri", 8'h00, o_primary_fault_flags);
		oe_is(1'b0);
	endtask : t_reset

	task automatic t_sec;
		cfg(8'h00, 8'h01, 1'b0);
		i_secondary_events = 8'h03;
		cyc(1);
		i_secondary_events = 8'h00;
		cyc(20);
		oe_is(1'b1);
		cyc(20);
		oe_is(1'b0);
		chk("sec", 8'h03, o_secondary_fault_flags);
		rd(3'h1);
		chk("sec", 8'h00, o_secondary_fault_flags);
	endtask : t_sec

	task automatic t_supply;
		want_low = 1'b1;
		cyc(6);
		oe_is(1'b0);
		want_low = 1'b0;
		cyc(6);
		chk("pri", 8'h01, o_primary_fault_flags);
		cfg(8'h01, 8'h00, 1'b0);
		want_low = 1'b1;
		cyc(6);
		oe_is(1'b1);
		want_low = 1'b0;
		cyc(40);
		oe_is(1'b0);
		chk("pri", 8'h01, o_primary_fault_flags);
		cfg(8'h01, 8'h00, 1'b1);
		cyc(2);
		oe_is(1'b1);
		rd(3'h2);
		cyc(40);
		oe_is(1'b0);
		chk("pri", 8'h00, o_primary_fault_flags);
	endtask : t_supply

	task automatic t_crc;
		frame(1'b1);
		cyc(5);
		rd(3'h2);
		chk("pri", 8'h10, o_primary_fault_flags);
		frame(1'b0);
		chk("pri", 8'h00, o_primary_fault_flags);
	endtask : t_crc

	task automatic t_capture;
		i_filter_bypass = 8'hff;
		want_field = 8'ha5;
		cyc(6);
		chk("chan", 8'ha5, o_field_channels);
		i_cs_n = 1'b0;
		cyc(4);
		want_field = 8'h5a;
		cyc(6);
		chk("chan", 8'ha5, o_field_channels);
		{i_cs_n, i_latch_n} = 2'h2;
		cyc(6);
		chk("chan", 8'ha5, o_field_channels);
		i_latch_n = 1'b1;
		cyc(6);
		chk("chan", 8'h5a, o_field_channels);
	endtask : t_capture

	task automatic t_filter;
		want_field = 8'h00;
		i_filter_bypass = 8'h00;
		i_channel_filter_config = 24'h000088;
		cyc(40);
		// limits 10, 20 and 80 counts; output moves in [5L, 5L+4]
		want_field = 8'h07;
		cyc(TDIV * 10 - 2);
		chk("chan", 8'h00, o_field_channels);
		cyc(8);
		chk("chan", 8'h01, o_field_channels);
		cyc(TDIV * 10);
		chk("chan", 8'h03, o_field_channels);
		cyc(TDIV * 60);
		chk("chan", 8'h07, o_field_channels);
		cyc(100);
		want_field = 8'h00;
		cyc(TDIV * 10 - 2);
		chk("chan", 8'h07, o_field_channels);
		cyc(8);
		chk("chan", 8'h06, o_field_channels);
		cyc(TDIV * 10);
		chk("chan", 8'h04, o_field_channels);
		cyc(TDIV * 60);
		chk("chan", 8'h00, o_field_channels);
	endtask : t_filter

	task automatic t_wire;
		cfg(8'h40, 8'h00, 1'b0);
		i_wire_break_enable = 8'h03;
		i_cs_n = 1'b0;
		want_trip = 8'h0f;
		cyc(TDIV * 4000 - 10);
		oe_is(1'b0);
		chk("wb", 8'h00, o_wire_break_flags);
		cyc(20);
		oe_is(1'b1);
		chk("wb", 8'h00, o_wire_break_flags);
		i_cs_n = 1'b1;
		cyc(6);
		chk("wb", 8'h03, o_wire_break_flags);
		chk("pri", 8'h40, o_primary_fault_flags);
		rd(3'h2);
		chk("pri", 8'h40, o_primary_fault_flags);
		cyc(1);
		rd(3'h4);
		chk("wb", 8'h03, o_wire_break_flags);
		i_wire_break_enable = 8'h00;
		cyc(1);
		rd(3'h4);
		chk("wb", 8'h00, o_wire_break_flags);
		chk("pri", 8'h00, o_primary_fault_flags);
	endtask : t_wire

	task automatic report_and_stop;
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (12) @(negedge i_clock);
		i_rst = 1'b0;
		t_reset();
		t_sec();
		t_supply();
		t_crc();
		t_capture();
		t_filter();
		t_wire();
		report_and_stop();
	end
endmodule : oif_monitor_test

`default_nettype wire
